//--- ldcfg_pkg.sv
// Package of constants and types for the LED driver configuration receiver.
package ldcfg_pkg;

    // ************************************************************
    // Timing constants.
    // ************************************************************
    // The core clock runs at 250 MHz.
    localparam int REF_CLK_PERIOD_PS = 4000;
    // Assumed serial clock period, in ns; the idle limit is measured from it.
    localparam int SERIAL_CLK_PERIOD_NS = 100;
    // Serial clock periods of silence that abort a transfer.
    localparam int IDLE_ABORT_PERIODS = 95;
    // Least time rounds up to whole core cycles.
    localparam int IDLE_ABORT_CYCLES = (IDLE_ABORT_PERIODS *
        SERIAL_CLK_PERIOD_NS * 1000 + REF_CLK_PERIOD_PS - 1) /
        REF_CLK_PERIOD_PS;
    localparam int IDLE_CNT_W = 12;

    // ************************************************************
    // Packet layout.
    // ************************************************************
    localparam logic [5:0] HDR_CFG_LONG = 6'h23;
    localparam logic [5:0] HDR_CFG_SHORT = 6'h37;
    localparam logic [5:0] HDR_GS_LONG = 6'h3F;
    localparam logic [5:0] HDR_GS_SHORT = 6'h2B;
    localparam logic [5:0] HDR_DC_LONG = 6'h33;
    localparam logic [5:0] HDR_DC_SHORT = 6'h27;
    localparam int HDR_BITS = 6;
    localparam int LONG_SET_BITS = 48;
    localparam int SHORT_SET_BITS = 30;
    localparam int BIT_CNT_W = 16;

    // ************************************************************
    // Reset values and field positions.
    // ************************************************************
    localparam logic [9:0] MAIN_CFG_RESET = 10'h27E;
    localparam logic [2:0] RESERVED_CFG_RESET = 3'h7;
    localparam int CF_DIV_HI = 9;
    localparam int CF_DIV_LO = 8;
    localparam int CF_CORR_OFF = 7;
    localparam int CF_RANGE_HI = 6;
    localparam int CF_RANGE_LO = 5;
    localparam int CF_CNT_RESET = 4;
    localparam int CF_AUTO_SYNC = 3;
    localparam int CF_CKO_HI = 2;
    localparam int CF_CKO_LO = 1;
    localparam int CF_PARITY_EN = 0;
    localparam logic [1:0] RANGE_HIGH = 2'h3;
    localparam logic [1:0] CKO_INVERT = 2'h3;
    localparam logic [3:0] CORR_BITS_LONG = 4'h8;
    localparam logic [3:0] CORR_BITS_SHORT = 4'h6;
    localparam int FIFO_DEPTH = 16;

    // ************************************************************
    // Types.
    // ************************************************************
    typedef enum logic [4:0] {
        LDCFG_HUNT = 5'b00001,
        LDCFG_HDR = 5'b00010,
        LDCFG_PRE = 5'b00100,
        LDCFG_DATA = 5'b01000,
        LDCFG_SKIP = 5'b10000
    } ldcfg_state_t;

    // One decoded configuration word set.
    typedef struct packed {
        logic main_ok;
        logic [9:0] main_cfg;
        logic [2:0] reserved_cfg;
    } ldcfg_word_t;

endpackage

//--- ldcfg_rx.sv
// Configuration packet receiver for a three-channel PWM LED driver.
// Overview of operation
// - Grayscale clock is oscillator divided 1 to 128.
// - Clock-range field picks high or low range.
// - Correction width 8 or 6 bits by mode.
// - Correction uses multiplier, refresh rate kept.
// - Counter-reset bit resets PWM after configuration.
// - Auto sync applies new data at cycle end.
// - Manual sync restarts PWM cycle immediately.
// - Output clock is input clock, inverted when CKO field is 11.
// - Parity guards preamble when checking enabled.
// - Long format: 48-bit preamble, three 16-bit words.
// - Long header 100011 twice, zero address.
// - Chain count minus one sent twice in long format, once in short.
// - Four odd-parity flags over preamble fields.
// - Long main bank written only if copies match.
// - Reserved bank taken from payload bits 2:0.
// - Last device data first, own data last.
// - Short format: 30-bit preamble, 10-bit words.
// - Short preamble fields at their fixed positions.
// - Short main bank written only if copies match.
// - Data sampled on serial clock falling edge.
// - Header hunted after first one, retried.
// - Clock pause over 95 periods aborts transfer.
// - Main bank resets to 1001111110.
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// Word FIFO between receiver and apply logic.
// ************************************************************
module ldcfg_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_reg, wr_next, rd_reg, rd_next;
    logic full, empty;

    // Pointers carry one extra bit so full and empty differ.
    always_comb begin
        full = (wr_reg[AW] != rd_reg[AW]) &&
            (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
        empty = (wr_reg == rd_reg);
        wr_next = wr_reg + ((in_valid && !full) ? 1'b1 : 1'b0);
        rd_next = rd_reg + ((out_ready && !empty) ? 1'b1 : 1'b0);
    end

    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_reg[AW-1:0]];

    // Storage has no reset; only valid slots are ever read.
    always_ff @(posedge ref_clk) begin
        if (in_valid && !full) begin
            mem[wr_reg[AW-1:0]] <= in_data;
        end
    end

    // Pointer registers.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
        end
    end
endmodule

// ************************************************************
// Top level receiver.
// ************************************************************
module ldcfg_rx
    import ldcfg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic serial_clock_in,
    input wire logic serial_data_in,
    input wire logic pwm_cycle_end,
    input wire logic gray_mode_long,
    output logic serial_clock_out,
    output logic serial_data_out,
    output logic grayscale_clock_en,
    output logic grayscale_range_high,
    output logic correction_enable,
    output logic [3:0] correction_bits,
    output logic pwm_counter_reset,
    output logic pwm_restart,
    output logic parity_check_en,
    output logic [9:0] main_config_bank,
    output logic [2:0] reserved_config_bank
);
    // Odd-parity flags of a preamble agree with its fields.
    function automatic logic parity_ok(input logic [3:0] p,
        input logic [9:0] l, input logic [9:0] a, input logic [5:0] h);
        parity_ok = (p[0] == ^l) && (p[1] == ^a) && (p[2] == ^h) &&
            (p[3] == ^p[2:0]);
    endfunction

    // ********************************************************
    // Pin synchronisers and edge detection.
    // ********************************************************
    logic [2:0] sclk_sync_reg, sclk_sync_next;
    logic [2:0] sdat_sync_reg, sdat_sync_next;
    logic sclk_lvl_reg, sclk_lvl_next, sdat_lvl_reg, sdat_lvl_next;
    logic fall, any_edge;
    logic [IDLE_CNT_W-1:0] idle_reg, idle_next;
    logic idle_abort;

    // A level counts once the second and third stages agree.
    always_comb begin
        sclk_sync_next = {sclk_sync_reg[1:0], serial_clock_in};
        sdat_sync_next = {sdat_sync_reg[1:0], serial_data_in};
        sclk_lvl_next = (sclk_sync_reg[1] == sclk_sync_reg[2]) ?
            sclk_sync_reg[2] : sclk_lvl_reg;
        sdat_lvl_next = (sdat_sync_reg[1] == sdat_sync_reg[2]) ?
            sdat_sync_reg[2] : sdat_lvl_reg;
        fall = sclk_lvl_reg && !sclk_lvl_next;
        any_edge = sclk_lvl_reg != sclk_lvl_next;
        // A stalled clock aborts the transfer in progress.
        idle_abort = (idle_reg == IDLE_CNT_W'(IDLE_ABORT_CYCLES));
        if (any_edge) begin
            idle_next = '0;
        end else if (!idle_abort) begin
            idle_next = idle_reg + 1'b1;
        end else begin
            idle_next = idle_reg;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sclk_sync_reg <= '0;
            sdat_sync_reg <= '0;
            sclk_lvl_reg <= 1'b0;
            sdat_lvl_reg <= 1'b0;
            idle_reg <= '0;
        end else begin
            sclk_sync_reg <= sclk_sync_next;
            sdat_sync_reg <= sdat_sync_next;
            sclk_lvl_reg <= sclk_lvl_next;
            sdat_lvl_reg <= sdat_lvl_next;
            idle_reg <= idle_next;
        end
    end

    // ********************************************************
    // Packet receiver.
    // ********************************************************
    ldcfg_state_t state_reg, state_next;
    logic [47:0] sr_reg, sr_next;
    logic [BIT_CNT_W-1:0] cnt_reg, cnt_next, total_reg, total_next;
    logic long_reg, long_next;
    logic push_reg, push_next;
    ldcfg_word_t word_reg, word_next, pop_word;
    logic fifo_in_ready, fifo_out_valid, fifo_pop;
    logic [47:0] sr_shift;
    logic [BIT_CNT_W-1:0] cnt_inc;
    logic [9:0] chain;
    logic pre_ok;

    always_comb begin
        state_next = state_reg;
        sr_next = sr_reg;
        cnt_next = cnt_reg;
        total_next = total_reg;
        long_next = long_reg;
        word_next = word_reg;
        push_next = push_reg && !fifo_in_ready;
        sr_shift = {sr_reg[46:0], sdat_lvl_reg};
        cnt_inc = cnt_reg + 1'b1;
        chain = sr_shift[9:0];
        // Long-format preamble copies must agree; parity is checked in both formats when enabled.
        if (long_reg) begin
            pre_ok = (sr_shift[47:42] == HDR_CFG_LONG) &&
                (sr_shift[31:26] == HDR_CFG_LONG) &&
                (sr_shift[41:32] == 10'h000) &&
                (sr_shift[25:16] == sr_shift[9:0]) &&
                (!main_config_bank[CF_PARITY_EN] ||
                parity_ok(sr_shift[15:12], sr_shift[25:16],
                sr_shift[41:32], sr_shift[47:42]));
        end else begin
            pre_ok = (sr_shift[29:24] == HDR_CFG_SHORT) &&
                (sr_shift[19:10] == 10'h000) &&
                (!main_config_bank[CF_PARITY_EN] ||
                parity_ok(sr_shift[23:20], sr_shift[9:0],
                sr_shift[19:10], sr_shift[29:24]));
        end
        if (idle_abort && state_reg != LDCFG_HUNT) begin
            state_next = LDCFG_HUNT;
        end else if (fall) begin
            case (state_reg)
                LDCFG_HUNT: begin
                    // A pending word holds off the next packet.
                    if (sdat_lvl_reg && !push_reg) begin
                        sr_next = 48'h0000_0000_0001;
                        cnt_next = BIT_CNT_W'(1);
                        state_next = LDCFG_HDR;
                    end
                end
                LDCFG_HDR: begin
                    sr_next = sr_shift;
                    cnt_next = cnt_inc;
                    if (cnt_inc == BIT_CNT_W'(HDR_BITS)) begin
                        if (sr_shift[5:0] == HDR_CFG_LONG ||
                            sr_shift[5:0] == HDR_CFG_SHORT) begin
                            long_next = sr_shift[5:0] == HDR_CFG_LONG;
                            state_next = LDCFG_PRE;
                        end else if (sr_shift[5:0] == HDR_GS_LONG ||
                            sr_shift[5:0] == HDR_GS_SHORT ||
                            sr_shift[5:0] == HDR_DC_LONG ||
                            sr_shift[5:0] == HDR_DC_SHORT) begin
                            state_next = LDCFG_SKIP;
                        end else begin
                            state_next = LDCFG_HUNT;
                        end
                    end
                end
                LDCFG_PRE: begin
                    sr_next = sr_shift;
                    cnt_next = cnt_inc;
                    if (cnt_inc == BIT_CNT_W'(long_reg ? LONG_SET_BITS :
                        SHORT_SET_BITS)) begin
                        cnt_next = '0;
                        total_next = BIT_CNT_W'((chain + 11'd1) *
                            (long_reg ? 6'd48 : 6'd30));
                        state_next = pre_ok ? LDCFG_DATA : LDCFG_SKIP;
                    end
                end
                LDCFG_DATA: begin
                    sr_next = sr_shift;
                    cnt_next = cnt_inc;
                    // Own word set is the last one in the packet.
                    if (cnt_inc == total_reg) begin
                        if (long_reg) begin
                            word_next.main_cfg = sr_shift[41:32];
                            word_next.main_ok =
                                sr_shift[41:32] == sr_shift[25:16];
                        end else begin
                            word_next.main_cfg = sr_shift[29:20];
                            word_next.main_ok =
                                sr_shift[29:20] == sr_shift[19:10];
                        end
                        word_next.reserved_cfg = sr_shift[2:0];
                        push_next = 1'b1;
                        state_next = LDCFG_SKIP;
                    end
                end
                LDCFG_SKIP: begin
                    state_next = LDCFG_SKIP;
                end
                default: begin
                    state_next = LDCFG_HUNT;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg <= LDCFG_HUNT;
            sr_reg <= '0;
            cnt_reg <= '0;
            total_reg <= '0;
            long_reg <= 1'b0;
            push_reg <= 1'b0;
            word_reg <= '0;
        end else begin
            state_reg <= state_next;
            sr_reg <= sr_next;
            cnt_reg <= cnt_next;
            total_reg <= total_next;
            long_reg <= long_next;
            push_reg <= push_next;
            word_reg <= word_next;
        end
    end

    ldcfg_fifo #(.WIDTH($bits(ldcfg_word_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .ref_clk(ref_clk),
        .rst(rst),
        .in_data(word_reg),
        .in_valid(push_reg),
        .in_ready(fifo_in_ready),
        .out_data(pop_word),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop)
    );

    // ********************************************************
    // Apply logic and outputs.
    // ********************************************************
    logic [9:0] main_next;
    logic [2:0] resv_next;
    logic [6:0] div_reg, div_next;
    logic [2:0] div_log2;
    logic grayscale_clock_next, cko_next, rst_pulse_next, restart_next;
    logic [3:0] corr_bits_next;

    // Auto sync waits for the running PWM cycle to finish; manual does not.
    assign fifo_pop = fifo_out_valid &&
        (!main_config_bank[CF_AUTO_SYNC] || pwm_cycle_end);

    always_comb begin
        main_next = main_config_bank;
        resv_next = reserved_config_bank;
        rst_pulse_next = 1'b0;
        restart_next = 1'b0;
        if (fifo_pop) begin
            if (pop_word.main_ok) begin
                main_next = pop_word.main_cfg;
            end
            resv_next = pop_word.reserved_cfg;
            rst_pulse_next = main_next[CF_CNT_RESET];
            restart_next = !main_config_bank[CF_AUTO_SYNC];
        end
        // Divide field counts down from fastest; low range adds 16x.
        div_log2 = {main_config_bank[CF_RANGE_HI:CF_RANGE_LO] != RANGE_HIGH,
            ~main_config_bank[CF_DIV_HI:CF_DIV_LO]};
        div_next = div_reg + 1'b1;
        grayscale_clock_next = &(div_reg | ~((7'h01 << div_log2) - 7'h01));
        // Forwarding inverted balances duty along the chain.
        cko_next = (main_config_bank[CF_CKO_HI:CF_CKO_LO] == CKO_INVERT) ?
            !sclk_lvl_reg : sclk_lvl_reg;
        // Multiplier width follows the grayscale mode.
        corr_bits_next = gray_mode_long ? CORR_BITS_LONG :
            CORR_BITS_SHORT;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            main_config_bank <= MAIN_CFG_RESET;
            reserved_config_bank <= RESERVED_CFG_RESET;
            div_reg <= '0;
            grayscale_clock_en <= 1'b0;
            grayscale_range_high <= 1'b1;
            serial_clock_out <= 1'b0;
            serial_data_out <= 1'b0;
            correction_enable <= 1'b1;
            correction_bits <= CORR_BITS_LONG;
            pwm_counter_reset <= 1'b0;
            pwm_restart <= 1'b0;
            parity_check_en <= 1'b0;
        end else begin
            main_config_bank <= main_next;
            reserved_config_bank <= resv_next;
            div_reg <= div_next;
            grayscale_clock_en <= grayscale_clock_next;
            grayscale_range_high <=
                main_config_bank[CF_RANGE_HI:CF_RANGE_LO] == RANGE_HIGH;
            serial_clock_out <= cko_next;
            serial_data_out <= sdat_lvl_reg;
            correction_enable <= !main_config_bank[CF_CORR_OFF];
            correction_bits <= corr_bits_next;
            pwm_counter_reset <= rst_pulse_next;
            pwm_restart <= restart_next;
            parity_check_en <= main_config_bank[CF_PARITY_EN];
        end
    end
endmodule

`default_nettype wire

//--- ldcfg_rx_asserts.sv
// Checker for the configuration receiver, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module ldcfg_rx_asserts
    import ldcfg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic serial_clock_in,
    input wire logic pwm_cycle_end,
    input wire logic gray_mode_long,
    input wire logic serial_clock_out,
    input wire logic grayscale_clock_en,
    input wire logic grayscale_range_high,
    input wire logic correction_enable,
    input wire logic [3:0] correction_bits,
    input wire logic pwm_counter_reset,
    input wire logic pwm_restart,
    input wire logic parity_check_en,
    input wire logic [9:0] main_config_bank
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    logic [3:0] since_end_reg, since_end_next;

    // Cycles since the last PWM cycle end; saturates, never wraps.
    always_comb begin
        since_end_next = since_end_reg;
        if (pwm_cycle_end) begin
            since_end_next = 4'h0;
        end else if (since_end_reg != 4'hf) begin
            since_end_next = since_end_reg + 4'h1;
        end
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            since_end_reg <= 4'hf;
        end else begin
            since_end_reg <= since_end_next;
        end
    end

    // Status outputs follow a settled bank; the correction width follows a settled grayscale mode.
    property p_corr;
        $stable(main_config_bank) |->
            correction_enable == !main_config_bank[CF_CORR_OFF];
    endproperty
    a_corr: assert property (p_corr)
        else $error("correction enable wrong");
    property p_range;
        $stable(main_config_bank) |-> grayscale_range_high ==
            (main_config_bank[CF_RANGE_HI:CF_RANGE_LO] == RANGE_HIGH);
    endproperty
    a_range: assert property (p_range)
        else $error("clock range wrong");
    property p_par;
        $stable(main_config_bank) |->
            parity_check_en == main_config_bank[CF_PARITY_EN];
    endproperty
    a_par: assert property (p_par)
        else $error("parity enable wrong");
    property p_cbits;
        $stable(gray_mode_long) |-> correction_bits ==
            (gray_mode_long ? CORR_BITS_LONG : CORR_BITS_SHORT);
    endproperty
    a_cbits: assert property (p_cbits)
        else $error("correction width wrong");
    // The forwarded clock is compared only once the input has settled.
    property p_cko;
        ($stable(serial_clock_in) && $stable(main_config_bank))[*8] |->
            serial_clock_out == (serial_clock_in ^
            (main_config_bank[CF_CKO_HI:CF_CKO_LO] == CKO_INVERT));
    endproperty
    a_cko: assert property (p_cko)
        else $error("forwarded clock polarity wrong");
    property p_auto;
        $changed(main_config_bank) && $past(main_config_bank[CF_AUTO_SYNC])
            |-> since_end_reg <= 4'h3;
    endproperty
    a_auto: assert property (p_auto)
        else $error("bank applied off cycle end");
    property p_restart;
        pwm_restart |-> !$past(main_config_bank[CF_AUTO_SYNC]) ##1 !pwm_restart;
    endproperty
    a_restart: assert property (p_restart)
        else $error("restart pulse outside manual sync");
    property p_cntrst;
        pwm_counter_reset |-> main_config_bank[CF_CNT_RESET]
            ##1 !pwm_counter_reset;
    endproperty
    a_cntrst: assert property (p_cntrst)
        else $error("stray counter reset");
    property p_gce;
        grayscale_clock_en && (main_config_bank[9:8] != 2'h3 ||
            main_config_bank[6:5] != RANGE_HIGH)
            |=> !grayscale_clock_en;
    endproperty
    a_gce: assert property (p_gce)
        else $error("divided clock enable too long");
endmodule
bind ldcfg_rx ldcfg_rx_asserts i_chk (
    .ref_clk,
    .rst,
    .serial_clock_in,
    .pwm_cycle_end,
    .gray_mode_long,
    .serial_clock_out,
    .grayscale_clock_en,
    .grayscale_range_high,
    .correction_enable,
    .correction_bits,
    .pwm_counter_reset,
    .pwm_restart,
    .parity_check_en,
    .main_config_bank
);
`default_nettype wire

//--- ldcfg_ctrl_model.sv
// Model of the controller driving the serial clock and data pair.
`timescale 1ns/1ps
`default_nettype none
module ldcfg_ctrl_model (
    input wire logic ref_clk,
    output logic serial_clock,
    output logic serial_data
);
    // Both lines rest low between packets.
    initial begin
        serial_clock = 1'b0;
        serial_data = 1'b0;
    end
    // Data moves mid low phase, so it never races the sampling edge.
    task automatic send(input logic [191:0] bits, input int len);
        for (int i = len - 1; i >= 0; i--) begin
            serial_data = bits[i];
            repeat (4) @(negedge ref_clk);
            serial_clock = 1'b1;
            repeat (8) @(negedge ref_clk);
            serial_clock = 1'b0;
            repeat (4) @(negedge ref_clk);
        end
        serial_data = 1'b0;
    endtask
    // Silence of 175 serial periods marks the next packet.
    task automatic gap();
        repeat (2800) @(negedge ref_clk);
    endtask
endmodule
`default_nettype wire

//--- ldcfg_rx_tb.sv
// Self-checking testbench for the configuration receiver.
`timescale 1ns/1ps
`default_nettype none
module ldcfg_rx_tb
    import ldcfg_pkg::*;
;
    typedef struct packed {
        logic [5:0] hdr;
        logic [9:0] cnt;
        logic [9:0] cf1;
        logic [9:0] cf1b;
        logic [2:0] cf2;
        logic [3:0] pflip;
        logic acc;
    } ldcfg_row_t;

    logic ref_clk = 1'b0;
    logic rst, sclk, sdat, gray_mode_long, saw_rst, saw_cnt;
    logic range_high, corr_en, par_en, cnt_rst, restart;
    logic pwm_cycle_end = 1'b0;
    logic [5:0] pce_cnt = 6'h00;
    logic [3:0] corr_bits;
    logic [9:0] main_bank;
    logic [2:0] res_bank;
    int err_total = 0;
    int n_checks = 0;
    ldcfg_row_t rows [10];

    always #2 ref_clk = ~ref_clk;

    // A PWM cycle ends every 64 core cycles.
    always @(negedge ref_clk) begin
        pce_cnt <= pce_cnt + 6'h01;
        pwm_cycle_end <= (pce_cnt == 6'h3f);
    end
    // One-cycle pulses are latched for later checks.
    always @(posedge ref_clk) begin
        if (restart === 1'b1) saw_rst = 1'b1;
        if (cnt_rst === 1'b1) saw_cnt = 1'b1;
    end

    ldcfg_ctrl_model i_ctrl (
        .ref_clk(ref_clk),
        .serial_clock(sclk),
        .serial_data(sdat)
    );
    ldcfg_rx i_dut (
        .ref_clk(ref_clk),
        .rst(rst),
        .serial_clock_in(sclk),
        .serial_data_in(sdat),
        .pwm_cycle_end(pwm_cycle_end),
        .gray_mode_long(gray_mode_long),
        .serial_clock_out(),
        .serial_data_out(),
        .grayscale_clock_en(),
        .grayscale_range_high(range_high),
        .correction_enable(corr_en),
        .correction_bits(corr_bits),
        .pwm_counter_reset(cnt_rst),
        .pwm_restart(restart),
        .parity_check_en(par_en),
        .main_config_bank(main_bank),
        .reserved_config_bank(res_bank)
    );

    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic check_cfg(input logic [9:0] m, input logic [2:0] s);
        chk(main_bank, m);
        chk(10'(res_bank), 10'(s));
        chk(10'(corr_en), 10'(!m[7]));
        chk(10'(range_high), 10'(m[6:5] == RANGE_HIGH));
        chk(10'(par_en), 10'(m[0]));
        chk(10'(corr_bits), gray_mode_long ? 10'h008 : 10'h006);
    endtask
    // Preamble, then a neighbour's set if count is nonzero, then our own set last.
    function automatic logic [191:0] pkt(input ldcfg_row_t r, output int n);
        logic [3:0] p;
        logic [47:0] s, o, pre;
        p[0] = ^r.cnt;
        p[1] = 1'b0;
        p[2] = ^r.hdr;
        p[3] = ^p[2:0];
        p = p ^ r.pflip;
        if (r.hdr == HDR_CFG_LONG) begin
            pre = {r.hdr, 10'h000, r.hdr, r.cnt, p, 2'h0,
                r.cnt};
            s = {6'h00, r.cf1, 6'h00, r.cf1b, 13'h0000, r.cf2};
            o = {6'h00, 10'h0aa, 6'h00, 10'h0aa, 13'h0000, 3'h1};
            n = 48 * (r.cnt + 2);
            pkt = (r.cnt == 0) ? {96'h0, pre, s} : {48'h0, pre, o, s};
        end else begin
            pre = {18'h0, r.hdr, p, 10'h000, r.cnt};
            s = {18'h0, r.cf1, r.cf1b, 7'h00, r.cf2};
            o = {18'h0, 10'h0aa, 10'h0aa, 7'h00, 3'h1};
            n = 30 * (r.cnt + 2);
            pkt = (r.cnt == 0) ? {132'h0, pre[29:0], s[29:0]} :
                {102'h0, pre[29:0], o[29:0], s[29:0]};
        end
    endfunction

    // Cuts a hang short.
    initial begin
        repeat (90000) @(posedge ref_clk);
        err_total++;
        end_sim();
    end

    initial begin
        ldcfg_row_t r;
        logic [191:0] b;
        int n;
        logic wr;
        logic [9:0] exp_m, main_q;
        logic [2:0] exp_r, res_q;
        // Columns: header, count, copy one, copy two, bank two, flip, accept.
        rows[0] = {HDR_CFG_LONG, 10'h000, 10'h1fa, 10'h1fa, 3'h5, 4'h0, 1'b1};
        rows[1] = {HDR_CFG_SHORT, 10'h001, 10'h27e, 10'h27e, 3'h7, 4'h0, 1'b1};
        rows[2] = {HDR_CFG_LONG, 10'h000, 10'h155, 10'h154, 3'h3, 4'h0, 1'b1};
        rows[3] = {HDR_CFG_SHORT, 10'h000, 10'h155, 10'h154, 3'h6, 4'h0, 1'b1};
        rows[4] = {HDR_CFG_LONG, 10'h000, 10'h27f, 10'h27f, 3'h7, 4'h0, 1'b1};
        rows[5] = {HDR_CFG_LONG, 10'h000, 10'h000, 10'h000, 3'h0, 4'h1, 1'b0};
        rows[6] = {HDR_GS_SHORT, 10'h000, 10'h000, 10'h000, 3'h0, 4'h0, 1'b0};
        rows[7] = {HDR_CFG_SHORT, 10'h000, 10'h316, 10'h316, 3'h2, 4'h0, 1'b1};
        rows[8] = {HDR_CFG_LONG, 10'h000, 10'h0de, 10'h0de, 3'h4, 4'h0, 1'b1};
        rows[9] = {HDR_CFG_LONG, 10'h001, 10'h27e, 10'h27e, 3'h7, 4'h0, 1'b1};
        rst = 1'b1;
        gray_mode_long = 1'b1;
        repeat (16) @(negedge ref_clk);
        check_cfg(MAIN_CFG_RESET, RESERVED_CFG_RESET);
        rst = 1'b0;
        i_ctrl.gap();
        main_q = MAIN_CFG_RESET;
        res_q = RESERVED_CFG_RESET;
        for (int i = 0; i < 10; i++) begin
            r = rows[i];
            wr = r.acc && (r.cf1 == r.cf1b);
            gray_mode_long = r.hdr == HDR_CFG_LONG;
            saw_rst = 1'b0;
            saw_cnt = 1'b0;
            b = pkt(r, n);
            i_ctrl.send(b, n);
            i_ctrl.gap();
            exp_m = wr ? r.cf1 : main_q;
            exp_r = r.acc ? r.cf2 : res_q;
            check_cfg(exp_m, exp_r);
            if (wr) begin
                chk(10'(saw_cnt), 10'(r.cf1[4]));
                chk(10'(saw_rst), 10'(!main_q[3]));
            end
            main_q = exp_m;
            res_q = exp_r;
        end
        // A second reset in mid-run brings both banks back.
        rst = 1'b1;
        repeat (4) @(negedge ref_clk);
        rst = 1'b0;
        repeat (8) @(negedge ref_clk);
        check_cfg(MAIN_CFG_RESET, RESERVED_CFG_RESET);
        // A packet cut short by a clock pause leaves the banks.
        r = rows[0];
        r.cf1 = 10'h000;
        r.cf1b = 10'h000;
        b = pkt(r, n);
        i_ctrl.send(b >> 40, n - 40);
        i_ctrl.gap();
        check_cfg(MAIN_CFG_RESET, RESERVED_CFG_RESET);
        end_sim();
    end
endmodule
`default_nettype wire
